// >>> include/qdsi_defs.vh
`ifndef QDSI_DEFS_VH
`define QDSI_DEFS_VH

// Serial word layout.
`define QDSI_WORD_W        12
`define QDSI_DATA_W        8
`define QDSI_SEL_HI_BIT    11
`define QDSI_SEL_LO_BIT    10
`define QDSI_CMD_HI_BIT    9
`define QDSI_CMD_LO_BIT    8
`define QDSI_DATA_MSB      7

// Command codes, high bit then low bit.
`define QDSI_CMD_SPECIAL   2'b00
`define QDSI_CMD_INPUT     2'b01
`define QDSI_CMD_COPY      2'b10
`define QDSI_CMD_BOTH      2'b11

// Channel selects used by the phase commands.
`define QDSI_SEL_PHASE1    2'b11
`define QDSI_SEL_PHASE0    2'b10

// Output phase modes and the value after reset.
`define QDSI_MODE_FALL     1'b0
`define QDSI_MODE_RISE     1'b1
`define QDSI_MODE_RESET    1'b1

// Register byte offsets.
`define QDSI_OFS_CTRL      12'h000
`define QDSI_OFS_STATUS    12'h004
`define QDSI_OFS_INPUT     12'h008
`define QDSI_OFS_DAC       12'h00c
`define QDSI_OFS_LASTWORD  12'h010
`define QDSI_OFS_CMDCOUNT  12'h014

// Control register fields.
`define QDSI_CTRL_CLEAR    0
`define QDSI_CTRL_LOAD     1

// Status register fields.
`define QDSI_STAT_MODE     0
`define QDSI_STAT_CS       1
`define QDSI_STAT_LOAD     2
`define QDSI_STAT_CLEAR    3
`define QDSI_STAT_CMDS_LSB 4

// Reset values.
`define QDSI_CODE_RESET    8'h00
`define QDSI_WORD_RESET    12'h000
`define QDSI_COUNT_RESET   16'h0000

`endif

// >>> logic/qdsi_shifter.v
`timescale 1ns/1ps
`include "qdsi_defs.vh"

module qdsi_shifter #(
    parameter WORD_W = 12
) (
    input  wire              clk,
    input  wire              rst_n,
    input  wire              sclk_rise,
    input  wire              sclk_fall,
    input  wire              selected,
    input  wire              din,
    input  wire              mode,
    output reg  [WORD_W-1:0] word,
    output reg               dout
);

    reg msb_hold_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word       <= `QDSI_WORD_RESET;
            msb_hold_r <= 1'b0;
            dout       <= 1'b0;
        end else if (selected) begin
            if (sclk_rise) begin
                word       <= {word[WORD_W-2:0], din};
                msb_hold_r <= word[WORD_W-1];
                if (mode == `QDSI_MODE_RISE) begin
                    dout <= word[WORD_W-1];
                end
            end
            // The bit leaving the register is kept so mode 0 shows it half a clock later.
            if (sclk_fall && mode == `QDSI_MODE_FALL) begin
                dout <= msb_hold_r;
            end
        end
    end

endmodule

// >>> logic/qdsi_sync.v
`timescale 1ns/1ps

module qdsi_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_r;

    // Two flops; only the second stage is ever read.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT;
            dout   <= INIT;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

// >>> logic/qdsi_top.v
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "qdsi_defs.vh"

// Notes on behaviour
// - Reset clears shifter and all code registers.
// - Output phase defaults to rising edge.
// - Words are twelve bits, most significant first.
// - Sixteen-bit words drop their first four bits.
// - Bits shift out while bits shift in.
// - Input sampled on rising clock when selected.
// - Output shows each bit twelve clocks later in mode 1.
// - Deselected interface ignores clock, holds output.
// - Serial output is always driven.
// - Commands execute only at select release.
// - Low load pin copies inputs into outputs.
// - Low clear pin zeroes all code registers.
// - Code 01 loads selected input register only.
// - Code 11 loads selected input and output.
// - Code 00, select low zero, loads all outputs.
// - Code 00, select low one, does nothing.
// - Code 10, select high zero, copies all.
// - Code 10, select 11, rising phase, copies.
// - Code 10, select 10, falling phase, copies.
// - Phase stays until reset or other command.
// - Output registers transparent while load low.
// - Mode 0 lags 12.5 clocks, mode 1 twelve.

module qdsi_top #(
    parameter CNT_W = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    input  wire        sclk,
    input  wire        cs_n,
    input  wire        serial_in,
    output wire        serial_out,
    input  wire        load_outputs_n,
    input  wire        clear_all_n,
    output wire [7:0]  dac_a_code,
    output wire [7:0]  dac_b_code,
    output wire [7:0]  dac_c_code,
    output wire [7:0]  dac_d_code,
    output wire        phase_mode
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    wire [4:0] pins_s;
    wire       sclk_s;
    wire       cs_n_s;
    wire       din_s;
    wire       load_n_s;
    wire       clear_n_s;

    qdsi_sync #(
        .WIDTH (5),
        .INIT  (5'b11110)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .din   ({clear_all_n, load_outputs_n, cs_n, serial_in, sclk}),
        .dout  (pins_s)
    );

    assign sclk_s    = pins_s[0];
    assign din_s     = pins_s[1];
    assign cs_n_s    = pins_s[2];
    assign load_n_s  = pins_s[3];
    assign clear_n_s = pins_s[4];

    reg sclk_d_r;
    reg cs_n_d_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire sclk_fall = ~sclk_s & sclk_d_r;
    wire cs_rise   = cs_n_s & ~cs_n_d_r;
    // Edges are only honoured while the device is selected.
    wire selected  = ~cs_n_s & ~cs_n_d_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial shifter.

    wire [`QDSI_WORD_W-1:0] word;
    reg                     mode_r;

    qdsi_shifter #(
        .WORD_W    (`QDSI_WORD_W)
    ) u_shift (
        .clk       (pclk),
        .rst_n     (presetn),
        .sclk_rise (sclk_rise),
        .sclk_fall (sclk_fall),
        .selected  (selected),
        .din       (din_s),
        .mode      (mode_r),
        .word      (word),
        .dout      (serial_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.

    wire [1:0]              cmd  = {word[`QDSI_CMD_HI_BIT], word[`QDSI_CMD_LO_BIT]};
    wire [1:0]              sel  = {word[`QDSI_SEL_HI_BIT], word[`QDSI_SEL_LO_BIT]};
    wire [`QDSI_DATA_W-1:0] data = word[`QDSI_DATA_MSB:0];

    function chan_hit;
        input [1:0] s;
        input [1:0] idx;
        begin
            chan_hit = (s == idx);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus write strobes.

    wire apb_access = psel & penable;
    wire apb_wr     = apb_access & pwrite;
    wire soft_clear = apb_wr & (paddr == `QDSI_OFS_CTRL) & pwdata[`QDSI_CTRL_CLEAR];
    wire soft_load  = apb_wr & (paddr == `QDSI_OFS_CTRL) & pwdata[`QDSI_CTRL_LOAD];

    ////////////////////////////////////////////////////////////////////////////////
    // Input and output code registers.

    reg [`QDSI_DATA_W-1:0]  in_r   [0:3];
    reg [`QDSI_DATA_W-1:0]  dac_r  [0:3];
    reg [`QDSI_DATA_W-1:0]  in_nxt [0:3];
    reg [`QDSI_DATA_W-1:0]  dac_nxt[0:3];
    reg                     mode_nxt;
    reg                     exec;
    integer                 i;
    integer                 j;

    always @* begin
        mode_nxt = mode_r;
        exec     = cs_rise;
        for (i = 0; i < 4; i = i + 1) begin
            in_nxt[i]  = in_r[i];
            dac_nxt[i] = dac_r[i];
        end
        if (exec) begin
            case (cmd)
                `QDSI_CMD_INPUT: begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (chan_hit(sel, i[1:0])) begin
                            in_nxt[i] = data;
                        end
                    end
                end
                `QDSI_CMD_BOTH: begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (chan_hit(sel, i[1:0])) begin
                            in_nxt[i]  = data;
                            dac_nxt[i] = data;
                        end
                    end
                end
                `QDSI_CMD_SPECIAL: begin
                    if (!sel[0]) begin
                        for (i = 0; i < 4; i = i + 1) begin
                            dac_nxt[i] = data;
                        end
                    end
                    // A set low select bit makes this the no-operation command.
                end
                `QDSI_CMD_COPY: begin
                    for (i = 0; i < 4; i = i + 1) begin
                        dac_nxt[i] = in_r[i];
                    end
                    if (sel == `QDSI_SEL_PHASE1) begin
                        mode_nxt = `QDSI_MODE_RISE;
                    end else if (sel == `QDSI_SEL_PHASE0) begin
                        mode_nxt = `QDSI_MODE_FALL;
                    end
                end
                default: begin
                    mode_nxt = mode_r;
                end
            endcase
        end
        if (soft_load) begin
            for (i = 0; i < 4; i = i + 1) begin
                dac_nxt[i] = in_nxt[i];
            end
        end
        // Transparent path: a same-cycle input update reaches the output register too.
        if (!load_n_s) begin
            for (i = 0; i < 4; i = i + 1) begin
                dac_nxt[i] = in_nxt[i];
            end
        end
        if (!clear_n_s || soft_clear) begin
            for (i = 0; i < 4; i = i + 1) begin
                in_nxt[i]  = `QDSI_CODE_RESET;
                dac_nxt[i] = `QDSI_CODE_RESET;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= `QDSI_MODE_RESET;
            for (j = 0; j < 4; j = j + 1) begin
                in_r[j]  <= `QDSI_CODE_RESET;
                dac_r[j] <= `QDSI_CODE_RESET;
            end
        end else begin
            mode_r <= mode_nxt;
            for (j = 0; j < 4; j = j + 1) begin
                in_r[j]  <= in_nxt[j];
                dac_r[j] <= dac_nxt[j];
            end
        end
    end

    assign dac_a_code = dac_r[0];
    assign dac_b_code = dac_r[1];
    assign dac_c_code = dac_r[2];
    assign dac_d_code = dac_r[3];
    assign phase_mode = mode_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Executed-word history.

    reg [`QDSI_WORD_W-1:0] last_word_r;
    reg [CNT_W-1:0]        cmd_count_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_word_r <= `QDSI_WORD_RESET;
            cmd_count_r <= {CNT_W{1'b0}};
        end else if (exec) begin
            last_word_r <= word;
            cmd_count_r <= cmd_count_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB read side; zero wait states, unmapped addresses answer with an error.

    assign pready = 1'b1;

    reg [31:0] rd_nxt;
    reg        err_nxt;

    always @* begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            `QDSI_OFS_CTRL: begin
                rd_nxt = 32'h0000_0000;
            end
            `QDSI_OFS_STATUS: begin
                rd_nxt[`QDSI_STAT_MODE]  = mode_r;
                rd_nxt[`QDSI_STAT_CS]    = cs_n_s;
                rd_nxt[`QDSI_STAT_LOAD]  = load_n_s;
                rd_nxt[`QDSI_STAT_CLEAR] = clear_n_s;
            end
            `QDSI_OFS_INPUT: begin
                rd_nxt = {in_r[3], in_r[2], in_r[1], in_r[0]};
            end
            `QDSI_OFS_DAC: begin
                rd_nxt = {dac_r[3], dac_r[2], dac_r[1], dac_r[0]};
            end
            `QDSI_OFS_LASTWORD: begin
                rd_nxt[`QDSI_WORD_W-1:0] = last_word_r;
            end
            `QDSI_OFS_CMDCOUNT: begin
                rd_nxt[CNT_W-1:0] = cmd_count_r;
            end
            default: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    // Data is registered in the setup cycle so it is stable for the access edge.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= err_nxt;
        end else if (!psel) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

endmodule

// >>> testbench/qdsi_master.sv
`timescale 1ns/1ps
module qdsi_master (
    output logic sclk,
    output logic cs_n,
    output logic serial_in,
    input  logic serial_out,
    output logic exp_bit,
    output logic got_bit
);
    logic lclk = 0;
    logic busy = 0;
    logic hist [$];
    always #80 lclk = ~lclk;
    initial begin
        sclk = 0;
        cs_n = 1;
        serial_in = 0;
        repeat (13) hist.push_back(1'b0);
    end
    // Outside a frame the data line is not held, so it toggles.
    always @(posedge lclk) if (!busy) serial_in <= ~serial_in;
    task automatic xfer(input logic [15:0] w, input int n);
        @(negedge lclk);
        busy = 1;
        cs_n <= 0;
        for (int b = n - 1; b >= 0; b--) begin
            serial_in <= w[b];
            @(posedge lclk);
            sclk <= 1;
            got_bit <= serial_out;
            exp_bit <= hist[hist.size() - 13];
            hist.push_back(w[b]);
            @(negedge lclk);
            sclk <= 0;
        end
        @(negedge lclk);
        cs_n <= 1;
        @(negedge lclk);
        busy = 0;
    endtask
    // Clock pulses while deselected, as another device on a shared clock would see.
    task automatic idle_pulses(input int n);
        repeat (n) begin
            @(posedge lclk);
            sclk <= 1;
            @(negedge lclk);
            sclk <= 0;
        end
    endtask
endmodule

// >>> testbench/qdsi_sva.sv
`timescale 1ns/1ps
module qdsi_sva (
    input wire       pclk,
    input wire       presetn,
    input wire       psel,
    input wire       pready,
    input wire       sclk,
    input wire       cs_n,
    input wire       serial_out,
    input wire       load_outputs_n,
    input wire       clear_all_n,
    input wire [7:0] dac_a_code,
    input wire [7:0] dac_b_code,
    input wire [7:0] dac_c_code,
    input wire [7:0] dac_d_code,
    input wire       phase_mode
);
    wire [31:0] codes = {dac_d_code, dac_c_code, dac_b_code, dac_a_code};
    wire        quiet = clear_all_n && load_outputs_n && !psel;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_reset_values: assert property ($rose(presetn) |-> codes == 32'h0 && phase_mode)
        else $error("codes or phase wrong after reset");
    a_codes_idle: assert property ((cs_n && quiet)[*8] |-> $stable(codes))
        else $error("codes moved while deselected");
    a_frame_stable: assert property ((!cs_n && quiet)[*6] |-> $stable({codes, phase_mode}))
        else $error("codes or phase moved inside a frame");
    a_clear_zero: assert property ((!clear_all_n)[*6] |-> codes == 32'h0)
        else $error("codes not cleared");
    a_rise_mode: assert property (phase_mode && $changed(serial_out) |-> sclk)
        else $error("serial out moved off rising phase");
    a_fall_mode: assert property (!phase_mode && $changed(serial_out) |-> !sclk)
        else $error("serial out moved off falling phase");
    a_out_hold: assert property (cs_n[*6] |-> $stable(serial_out))
        else $error("serial out moved while deselected");
    a_ready_high: assert property (psel |-> pready)
        else $error("ready low");
endmodule
bind qdsi_top qdsi_sva u_qdsi_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .pready(pready), .sclk(sclk), .cs_n(cs_n), .serial_out(serial_out),
    .load_outputs_n(load_outputs_n), .clear_all_n(clear_all_n), .dac_a_code(dac_a_code),
    .dac_b_code(dac_b_code), .dac_c_code(dac_c_code), .dac_d_code(dac_d_code),
    .phase_mode(phase_mode));

// >>> testbench/test_quad_dac_serial_command_interface.sv
`timescale 1ns/1ps
`include "qdsi_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_quad_dac_serial_command_interface;
    logic            pclk = 0;
    logic            presetn = 0;
    logic            psel = 0;
    logic            penable = 0;
    logic            pwrite = 0;
    logic [11:0]     paddr = 12'h000;
    logic [31:0]     pwdata = 32'h0;
    logic            load_outputs_n = 1;
    logic            clear_all_n = 1;
    wire  [31:0]     prdata;
    wire             pready, pslverr, sclk, cs_n, serial_in, serial_out, phase_mode, eb, gb;
    wire  [7:0]      dac_a_code, dac_b_code, dac_c_code, dac_d_code;
    logic [3:0][7:0] inp, dac;
    logic            mode, er;
    logic [31:0]     rd;
    logic [31:0]     ex;
    logic [15:0]     w;
    int              errors = 0, check_count = 0, seed = 32'h2e32, frames = 0;
    qdsi_top u_qdsi_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
        .serial_out(serial_out), .load_outputs_n(load_outputs_n), .clear_all_n(clear_all_n),
        .dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .dac_c_code(dac_c_code),
        .dac_d_code(dac_d_code), .phase_mode(phase_mode));
    qdsi_master u_qdsi_master (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
        .serial_out(serial_out), .exp_bit(eb), .got_bit(gb));
    always #2 pclk = ~pclk;
    always @(posedge sclk) begin #1; if (!cs_n) `CHK("serial_out", eb, gb) end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic apply(input logic [11:0] c);
        case (c[9:8])
            2'b01: inp[c[11:10]] = c[7:0];
            2'b11: begin
                inp[c[11:10]] = c[7:0];
                dac[c[11:10]] = c[7:0];
            end
            2'b00: if (!c[10]) dac = {4{c[7:0]}};
            default: begin
                if (c[11]) mode = c[10];
                dac = inp;
            end
        endcase
        if (!load_outputs_n) dac = inp;
    endtask
    task automatic check_all;
        apb(1'b0, `QDSI_OFS_INPUT, 32'h0);
        `CHK("input regs", inp, rd)
        apb(1'b0, `QDSI_OFS_DAC, 32'h0);
        `CHK("dac regs", dac, rd)
        `CHK("dac codes", dac, {dac_d_code, dac_c_code, dac_b_code, dac_a_code})
        `CHK("phase", mode, phase_mode)
    endtask
    task automatic conclude;
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        errors++;
        conclude;
    end
    // Every select and command pair three times, the middle third as 16-bit frames.
    initial begin
        inp = 0;
        dac = 0;
        mode = 1;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        check_all;
        for (int i = 0; i < 48; i++) begin
            w = 16'($random(seed));
            w[11:8] = i[3:0];
            if (i[2]) u_qdsi_master.idle_pulses(3);
            @(posedge pclk);
            load_outputs_n <= !i[5];
            u_qdsi_master.xfer(w, i[4] ? 16 : 12);
            frames++;
            apply(w[11:0]);
            check_all;
        end
        @(posedge pclk);
        load_outputs_n <= 1;
        repeat (4) @(posedge pclk);
        w = 16'($random(seed));
        w[11:8] = 4'h1;
        u_qdsi_master.xfer(w, 12);
        frames++;
        apply(w[11:0]);
        check_all;
        apb(1'b0, `QDSI_OFS_LASTWORD, 32'h0);
        `CHK("last word", {20'h0, w[11:0]}, rd)
        apb(1'b0, `QDSI_OFS_CMDCOUNT, 32'h0);
        `CHK("command count", frames, rd)
        apb(1'b1, `QDSI_OFS_CTRL, 32'h1 << `QDSI_CTRL_LOAD);
        dac = inp;
        check_all;
        apb(1'b1, `QDSI_OFS_CTRL, 32'h1 << `QDSI_CTRL_CLEAR);
        inp = 0;
        dac = 0;
        check_all;
        @(posedge pclk);
        clear_all_n <= 0;
        load_outputs_n <= 1;
        repeat (8) @(posedge pclk);
        inp = 0;
        dac = 0;
        check_all;
        clear_all_n <= 1;
        apb(1'b1, 12'h020, 32'hffffffff);
        `CHK("write error", 1'b1, er)
        apb(1'b0, 12'h020, 32'h0);
        `CHK("read error", 1'b1, er)
        `CHK("read data", 32'h0, rd)
        check_all;
        ex = 32'h0;
        ex[`QDSI_STAT_MODE] = mode;
        ex[`QDSI_STAT_CS] = 1'b1;
        ex[`QDSI_STAT_LOAD] = 1'b1;
        ex[`QDSI_STAT_CLEAR] = 1'b1;
        apb(1'b0, `QDSI_OFS_STATUS, 32'h0);
        `CHK("status", ex, rd)
        conclude;
    end
endmodule
